//--- swc_watchdog_config.sv
// watchdog timer behind a keyed index/data configuration port
`timescale 1ns/1ps
`include "swc_map.svh"

// What this block does
// - after reset, normal mode; devices off except keyboard controller, enable from strap
// - four key bytes 87h 01h 55h 55h at the index port unlock configuration
// - this key selects 2Eh as index port and 2Fh as data port
// - registers reachable only unlocked; index 07h selects device; watchdog is 07h
// - writing bit 1 of control at 02h returns to waiting for the key
// - configure control is write only, not held, cleared by reset
// - writing bit 0 of configure control resets all configuration registers
// - control bits 7,6,5 enable reload on infrared, mouse, keyboard interrupts
// - control bit 4 enables reload on any game port access
// - control bit 1 forces an immediate time-out and clears itself
// - control bit 0 reports time-out status; bits 3 and 2 reserved
// - configuration bit 7 picks seconds when one, minutes when zero
// - configuration bit 6 lets time-out pulse keyboard reset; bits 5,4 reserved
// - configuration bits 3-0 pick interrupt line 12, 3, 1 or none
// - time-out value holds 8-bit count; all three registers reset to zero
module swc_watchdog_config
#(
    parameter int unsigned CYC_PER_SEC = `SWC_SECOND_NS / `SWC_CLK_NS
)
(
    input  wire logic                     clk,
    input  wire logic                     rst,
    input  wire swc_pkg::swc_io_req_s     io_req,
    input  wire swc_pkg::swc_reload_evt_s reload_evt,
    input  wire logic                     kbd_strap,
    output logic [7:0]                    io_rdata_q,
    output logic                          io_rvalid_q,
    output logic                          kbd_ctrl_enable_q,
    output logic                          config_mode_q,
    output logic                          keyboard_reset_output_n_q,
    output logic [15:0]                   irq_q
);
    import swc_pkg::*;

    localparam int unsigned KEYBOARD_RESET_OUTPUT_CYC = (`SWC_KEYBOARD_RESET_OUTPUT_NS + `SWC_CLK_NS - 1) / `SWC_CLK_NS;
    localparam int unsigned MIN_LAST = `SWC_SEC_PER_MIN - 1;

    swc_key_state_e key_q;
    swc_key_state_e key_d;
    logic [7:0]     index_q;
    logic [7:0]     logical_device_number_q;
    logic [7:0]     wd_ctrl_q;
    logic [7:0]     wd_conf_q;
    logic [7:0]     wd_tov_q;
    logic [7:0]     count_q;
    logic [31:0]    sec_cnt_q;
    logic [5:0]     min_cnt_q;
    logic           status_q;
    logic [7:0]     keyboard_reset_output_cnt_q;

    logic           idx_wr;
    logic           dat_wr;
    logic           dat_rd;
    logic           wd_sel;
    logic           cc_wr;
    logic           soft_rst;
    logic           wc_wr;
    logic           cf_wr;
    logic           tov_wr;
    logic           force_to;
    logic           reload;
    logic           sec_tick;
    logic           unit_tick;
    logic           expire;
    logic           timeout;
    logic           restart;
    logic [7:0]     rd_val;

    // decode of the index/data pair, only alive while unlocked
    assign idx_wr = io_req.wr && io_req.addr == `SWC_INDEX_PORT && key_q == SWC_CONFIG;
    assign dat_wr = io_req.wr && io_req.addr == `SWC_DATA_PORT && key_q == SWC_CONFIG;
    assign dat_rd = io_req.rd && io_req.addr == `SWC_DATA_PORT && key_q == SWC_CONFIG;
    assign wd_sel = logical_device_number_q == `SWC_LDN_WATCHDOG;

    // write strobes per register
    assign cc_wr    = dat_wr && index_q == `SWC_IDX_CFG_CTRL;
    assign soft_rst = cc_wr && io_req.data[`SWC_CC_SOFT_RST];
    assign wc_wr    = dat_wr && wd_sel && index_q == `SWC_IDX_WD_CTRL;
    assign cf_wr    = dat_wr && wd_sel && index_q == `SWC_IDX_WD_CONF;
    assign tov_wr   = dat_wr && wd_sel && index_q == `SWC_IDX_WD_TOV;
    assign force_to = wc_wr && io_req.data[`SWC_WC_FORCE];

    // reload sources, each gated by its enable bit
    assign reload = (wd_ctrl_q[`SWC_WC_IR]    && reload_evt.ir_irq)
                 || (wd_ctrl_q[`SWC_WC_MOUSE] && reload_evt.mouse_irq)
                 || (wd_ctrl_q[`SWC_WC_KBD]   && reload_evt.kbd_irq)
                 || (wd_ctrl_q[`SWC_WC_GAME]  && (io_req.rd || io_req.wr)
                     && io_req.addr == `SWC_GAME_PORT_BASE);

    // time base: seconds, and minutes counted from seconds
    assign sec_tick  = sec_cnt_q == 32'(CYC_PER_SEC - 1);
    assign unit_tick = sec_tick && (wd_conf_q[`SWC_CF_UNIT_SEC]
                       || min_cnt_q == 6'(MIN_LAST));
    assign expire    = unit_tick && count_q == 8'h01;
    assign timeout   = expire || force_to;
    assign restart   = tov_wr || (reload && wd_tov_q != 8'h00);

    // key sequencer; a wrong byte drops back, 87h always restarts the key
    always_comb
    begin
        key_d = key_q;
        case (key_q)
            SWC_WAIT_KEY, SWC_KEY_1, SWC_KEY_2, SWC_KEY_3:
            begin
                if (io_req.wr && io_req.addr == `SWC_INDEX_PORT)
                begin
                    if (key_q == SWC_KEY_1 && io_req.data == `SWC_KEY1)
                        key_d = SWC_KEY_2;
                    else if (key_q == SWC_KEY_2 && io_req.data == `SWC_KEY2)
                        key_d = SWC_KEY_3;
                    else if (key_q == SWC_KEY_3 && io_req.data == `SWC_KEY3)
                        key_d = SWC_CONFIG;
                    else if (io_req.data == `SWC_KEY0)
                        key_d = SWC_KEY_1;
                    else
                        key_d = SWC_WAIT_KEY;
                end
            end
            SWC_CONFIG:
            begin
                if (cc_wr && io_req.data[`SWC_CC_EXIT])
                    key_d = SWC_WAIT_KEY;
            end
            default:
                key_d = SWC_WAIT_KEY;
        endcase
    end

    // key state register, reset into normal (locked) mode
    always_ff @(posedge clk)
    begin
        if (rst)
            key_q <= SWC_WAIT_KEY;
        else
            key_q <= key_d;
    end

    // unlocked-mode indicator
    always_ff @(posedge clk)
    begin
        if (rst)
            config_mode_q <= 1'b0;
        else
            config_mode_q <= key_d == SWC_CONFIG;
    end

    // keyboard controller enable follows the strap caught during reset
    always_ff @(posedge clk)
    begin
        if (rst)
            kbd_ctrl_enable_q <= kbd_strap;
    end

    // index and logical device number; configure control holds nothing
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            index_q                 <= 8'h00;
            logical_device_number_q <= `SWC_LDN_RESET;
        end
        else
        begin
            if (idx_wr)
                index_q <= io_req.data;
            if (soft_rst)
                logical_device_number_q <= `SWC_LDN_RESET;
            else if (dat_wr && index_q == `SWC_IDX_LDN)
                logical_device_number_q <= io_req.data;
        end
    end

    // watchdog registers; force and reserved bits are never stored
    always_ff @(posedge clk)
    begin
        if (rst || soft_rst)
        begin
            wd_ctrl_q <= `SWC_WD_RESET;
            wd_conf_q <= `SWC_WD_RESET;
            wd_tov_q  <= `SWC_WD_RESET;
        end
        else
        begin
            if (wc_wr)
                wd_ctrl_q <= io_req.data & `SWC_WC_RW_MASK;
            if (cf_wr)
                wd_conf_q <= io_req.data & `SWC_CF_RW_MASK;
            if (tov_wr)
                wd_tov_q <= io_req.data;
        end
    end

    // status: a new time-out wins over a write-one clear in the same cycle
    always_ff @(posedge clk)
    begin
        if (rst || soft_rst)
            status_q <= 1'b0;
        else if (timeout)
            status_q <= 1'b1;
        else if (wc_wr && io_req.data[`SWC_WC_STATUS])
            status_q <= 1'b0;
    end

    // prescaler, cleared whenever the count is (re)loaded
    always_ff @(posedge clk)
    begin
        if (rst || soft_rst || restart || count_q == 8'h00)
        begin
            sec_cnt_q <= 32'h0000_0000;
            min_cnt_q <= 6'h00;
        end
        else if (sec_tick)
        begin
            sec_cnt_q <= 32'h0000_0000;
            if (min_cnt_q == 6'(MIN_LAST))
                min_cnt_q <= 6'h00;
            else
                min_cnt_q <= min_cnt_q + 6'h01;
        end
        else
            sec_cnt_q <= sec_cnt_q + 32'h0000_0001;
    end

    // down-counter; zero means stopped
    always_ff @(posedge clk)
    begin
        if (rst || soft_rst)
            count_q <= 8'h00;
        else if (tov_wr)
            count_q <= io_req.data;
        else if (reload && wd_tov_q != 8'h00)
            count_q <= wd_tov_q;
        else if (unit_tick && count_q != 8'h00)
            count_q <= count_q - 8'h01;
    end

    // keyboard reset pulse of fixed width on time-out when enabled
    always_ff @(posedge clk)
    begin
        if (rst || soft_rst)
            keyboard_reset_output_cnt_q <= 8'h00;
        else if (timeout && wd_conf_q[`SWC_CF_KEYBOARD_RESET_OUTPUT_EN])
            keyboard_reset_output_cnt_q <= 8'(KEYBOARD_RESET_OUTPUT_CYC);
        else if (keyboard_reset_output_cnt_q != 8'h00)
            keyboard_reset_output_cnt_q <= keyboard_reset_output_cnt_q - 8'h01;
    end

    // active-low reset output, low while the pulse counter runs
    always_ff @(posedge clk)
    begin
        if (rst)
            keyboard_reset_output_n_q <= 1'b1;
        else
            keyboard_reset_output_n_q <= !(keyboard_reset_output_cnt_q > 8'h01 ||
                (timeout && wd_conf_q[`SWC_CF_KEYBOARD_RESET_OUTPUT_EN]) || keyboard_reset_output_cnt_q == 8'h01);
    end

    // interrupt line held while status is set; invalid selections drive nothing
    always_ff @(posedge clk)
    begin
        if (rst)
            irq_q <= 16'h0000;
        else
        begin
            irq_q <= 16'h0000;
            if (status_q)
            begin
                case (wd_conf_q[3:0])
                    `SWC_IRQ_SEL_12: irq_q[12] <= 1'b1;
                    `SWC_IRQ_SEL_3:  irq_q[3]  <= 1'b1;
                    `SWC_IRQ_SEL_1:  irq_q[1]  <= 1'b1;
                    default:         irq_q     <= 16'h0000;
                endcase
            end
        end
    end

    // read mux of the data port
    always_comb
    begin
        rd_val = 8'h00;
        case (index_q)
            `SWC_IDX_LDN:     rd_val = logical_device_number_q;
            `SWC_IDX_WD_CTRL: rd_val = wd_sel ? {wd_ctrl_q[7:1], status_q} : 8'h00;
            `SWC_IDX_WD_CONF: rd_val = wd_sel ? wd_conf_q : 8'h00;
            `SWC_IDX_WD_TOV:  rd_val = wd_sel ? wd_tov_q : 8'h00;
            default:          rd_val = 8'h00;
        endcase
    end

    // registered read answer, one cycle after the read strobe
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            io_rdata_q  <= 8'h00;
            io_rvalid_q <= 1'b0;
        end
        else
        begin
            io_rvalid_q <= io_req.rd;
            io_rdata_q  <= dat_rd ? rd_val : 8'h00;
        end
    end

endmodule // swc_watchdog_config

//--- swc_map.svh
// register offsets, field positions, reset values and timing counts of the watchdog gate
`ifndef SWC_MAP_SVH
`define SWC_MAP_SVH

// configuration port pair and unlock key
`define SWC_INDEX_PORT      16'h002E
`define SWC_DATA_PORT       16'h002F
`define SWC_KEY0            8'h87
`define SWC_KEY1            8'h01
`define SWC_KEY2            8'h55
`define SWC_KEY3            8'h55

// game port base whose accesses may reload the counter
`define SWC_GAME_PORT_BASE  16'h0201

// configuration register indices
`define SWC_IDX_CFG_CTRL    8'h02
`define SWC_IDX_LDN         8'h07
`define SWC_IDX_WD_CTRL     8'h71
`define SWC_IDX_WD_CONF     8'h72
`define SWC_IDX_WD_TOV      8'h73
`define SWC_LDN_WATCHDOG    8'h07

// configure control fields
`define SWC_CC_SOFT_RST     0
`define SWC_CC_EXIT         1

// watchdog control fields
`define SWC_WC_STATUS       0
`define SWC_WC_FORCE        1
`define SWC_WC_GAME         4
`define SWC_WC_KBD          5
`define SWC_WC_MOUSE        6
`define SWC_WC_IR           7
`define SWC_WC_RW_MASK      8'hF0

// watchdog configuration fields
`define SWC_CF_UNIT_SEC     7
`define SWC_CF_KEYBOARD_RESET_OUTPUT_EN      6
`define SWC_CF_RW_MASK      8'hCF
`define SWC_IRQ_SEL_12      4'hC
`define SWC_IRQ_SEL_3       4'h3
`define SWC_IRQ_SEL_1       4'h1

// reset values
`define SWC_WD_RESET        8'h00
`define SWC_LDN_RESET       8'h00

// timing
`define SWC_CLK_NS          5
`define SWC_SECOND_NS       1000000000
`define SWC_SEC_PER_MIN     60
`define SWC_KEYBOARD_RESET_OUTPUT_NS         500

`endif

//--- swc_pkg.sv
// types shared by the watchdog configuration gate
package swc_pkg;

    // one host i/o cycle, presented for one clock
    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [15:0] addr;
        logic [7:0]  data;
    } swc_io_req_s;

    // interrupt events that may reload the counter
    typedef struct packed {
        logic ir_irq;
        logic mouse_irq;
        logic kbd_irq;
    } swc_reload_evt_s;

    // unlock key sequencer states
    typedef enum logic [4:0] {
        SWC_WAIT_KEY = 5'b00001,
        SWC_KEY_1    = 5'b00010,
        SWC_KEY_2    = 5'b00100,
        SWC_KEY_3    = 5'b01000,
        SWC_CONFIG   = 5'b10000
    } swc_key_state_e;

endpackage

//--- swc_watchdog_config_asserts.sv
// concurrent checks on the ports of the watchdog configuration gate
`timescale 1ns/1ps
module swc_watchdog_config_asserts
#(
    parameter int unsigned CYC_PER_SEC = 20
)
(
    input wire logic                     clk,
    input wire logic                     rst,
    input wire swc_pkg::swc_io_req_s     io_req,
    input wire swc_pkg::swc_reload_evt_s reload_evt,
    input wire logic                     kbd_strap,
    input wire logic [7:0]               io_rdata_q,
    input wire logic                     io_rvalid_q,
    input wire logic                     kbd_ctrl_enable_q,
    input wire logic                     config_mode_q,
    input wire logic                     keyboard_reset_output_n_q,
    input wire logic [15:0]              irq_q
);
    import swc_pkg::*;
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    // length of the current keyboard reset pulse
    logic [7:0] low_cnt_q;
    always_ff @(posedge clk)
    begin
        if (rst || keyboard_reset_output_n_q)
            low_cnt_q <= 8'h00;
        else
            low_cnt_q <= low_cnt_q + 8'h01;
    end

    AST_RD_ANSWER: assert property (io_req.rd |=> io_rvalid_q)
        else $error("read got no answer");
    AST_RD_ONLY: assert property (!io_req.rd |=> !io_rvalid_q)
        else $error("answer without read");
    AST_LOCKED_RD: assert property (!config_mode_q && io_req.rd |=> io_rdata_q == 8'h00)
        else $error("locked read returned data");
    AST_UNLOCK: assert property ($rose(config_mode_q) |-> $past(io_req.wr)
        && $past(io_req.addr) == 16'h002E && $past(io_req.data) == 8'h55)
        else $error("unlocked without last key byte");
    AST_EXIT: assert property ($fell(config_mode_q) |-> $past(io_req.wr)
        && $past(io_req.addr) == 16'h002F && $past(io_req.data[1]))
        else $error("locked without exit write");
    AST_IRQ_LINES: assert property ((irq_q & 16'hEFF5) == 16'h0000)
        else $error("interrupt on unselectable line");
    AST_IRQ_ONE: assert property ($onehot0(irq_q))
        else $error("several interrupt lines high");
    AST_KEYBOARD_RESET_OUTPUT_WIDTH: assert property ($rose(keyboard_reset_output_n_q) |-> low_cnt_q == 8'h65)
        else $error("keyboard reset pulse width wrong");
    AST_STRAP: assert property (!$past(rst) |-> $stable(kbd_ctrl_enable_q))
        else $error("keyboard enable moved outside reset");

    // main scenarios reached
    cover property ($rose(config_mode_q));
    cover property ($fell(keyboard_reset_output_n_q));
    cover property (irq_q[12]);
    cover property (irq_q[3]);
endmodule // swc_watchdog_config_asserts

//--- swc_host_model.sv
// host model issuing i/o cycles to the configuration port pair
`timescale 1ns/1ps
module swc_host_model
(
    input  wire logic                clk,
    input  wire logic [7:0]          io_rdata_q,
    output swc_pkg::swc_io_req_s     io_req,
    output swc_pkg::swc_reload_evt_s reload_evt
);
    import swc_pkg::*;

    // quiet bus at time zero
    initial
    begin
        io_req     = '0;
        reload_evt = '0;
    end

    // one strobe cycle; idle bus shows the inverse of the last cycle
    task automatic cyc(input logic w, input logic [15:0] a, input logic [7:0] d);
        @(negedge clk);
        io_req <= '{wr: w, rd: !w, addr: a, data: d};
        @(negedge clk);
        io_req <= '{wr: 1'b0, rd: 1'b0, addr: ~a, data: ~d};
    endtask

    // read answer is taken the cycle after the strobe
    task automatic rd(input logic [15:0] a, output logic [7:0] d);
        cyc(1'b0, a, 8'h00);
        d = io_rdata_q;
    endtask

    // four key bytes to the index port
    task automatic key(input logic [31:0] k);
        for (int i = 0; i < 4; i++)
            cyc(1'b1, 16'h002E, k[31 - 8 * i -: 8]);
    endtask

    // indexed register access through the port pair
    task automatic reg_wr(input logic [7:0] i, input logic [7:0] d);
        cyc(1'b1, 16'h002E, i);
        cyc(1'b1, 16'h002F, d);
    endtask

    task automatic reg_rd(input logic [7:0] i, output logic [7:0] d);
        cyc(1'b1, 16'h002E, i);
        rd(16'h002F, d);
    endtask

    // one-cycle interrupt event
    task automatic evt(input swc_reload_evt_s e);
        @(negedge clk);
        reload_evt <= e;
        @(negedge clk);
        reload_evt <= '0;
    endtask
endmodule // swc_host_model

//--- swc_watchdog_config_tb_top.sv
// self-checking bench for the watchdog configuration gate
`timescale 1ns/1ps
module swc_watchdog_config_tb_top;
    import swc_pkg::*;
    localparam int unsigned CPS = 20;
    logic              clk = 1'b0;
    logic              rst = 1'b1;
    logic              kbd_strap = 1'b1;
    swc_io_req_s       io_req;
    swc_reload_evt_s   reload_evt;
    logic [7:0]        io_rdata_q;
    logic              io_rvalid_q;
    logic              kbd_ctrl_enable_q;
    logic              config_mode_q;
    logic              keyboard_reset_output_n_q;
    logic [15:0]       irq_q;
    int                error_cnt = 0;
    int                tests_run = 0;
    logic [7:0]        sel [6] = '{8'h4C, 8'h03, 8'h01, 8'h00, 8'h02, 8'h0D};
    logic [15:0]       exp_irq [6] = '{16'h1000, 16'h0008, 16'h0002, 16'h0, 16'h0, 16'h0};

    always #2.5 clk = ~clk;

    swc_watchdog_config #(.CYC_PER_SEC(CPS)) i_dut
    (
        .clk(clk), .rst(rst), .io_req(io_req), .reload_evt(reload_evt),
        .kbd_strap(kbd_strap), .io_rdata_q(io_rdata_q), .io_rvalid_q(io_rvalid_q),
        .kbd_ctrl_enable_q(kbd_ctrl_enable_q), .config_mode_q(config_mode_q),
        .keyboard_reset_output_n_q(keyboard_reset_output_n_q), .irq_q(irq_q)
    );

    swc_host_model host
    (
        .clk(clk), .io_rdata_q(io_rdata_q), .io_req(io_req), .reload_evt(reload_evt)
    );

    // comparisons of port values and register bytes
    task automatic cmp_sig(input logic [15:0] got, input logic [15:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic cmp_reg(input logic [7:0] got, input logic [7:0] exp);
        cmp_sig({8'h00, got}, {8'h00, exp});
    endtask

    task automatic chk_rd(input logic [7:0] i, input logic [7:0] exp);
        logic [7:0] d;
        host.reg_rd(i, d);
        cmp_reg(d, exp);
    endtask

    task automatic cyc_wait(input int n);
        repeat (n) @(negedge clk);
    endtask

    task automatic end_sim();
        $display("comparisons %0d mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    // hang guard
    initial
    begin
        #200000;
        error_cnt++;
        end_sim();
    end

    // main sequence
    initial
    begin
        logic [7:0] d;
        logic [7:0] v;
        cyc_wait(12);
        rst = 1'b0;
        cmp_sig(kbd_ctrl_enable_q, 1'h1);
        cmp_sig(config_mode_q, 1'h0);
        host.rd(16'h002F, d);
        cmp_sig(io_rvalid_q, 1'h1);
        cmp_reg(d, 8'h00);
        host.key(32'h870155AA);
        cmp_sig(config_mode_q, 1'h0);
        host.key(32'h87015555);
        cmp_sig(config_mode_q, 1'h1);
        host.reg_wr(8'h07, 8'h07);
        for (v = 8'h71; v < 8'h74; v++)
            chk_rd(v, 8'h00);
        host.reg_wr(8'h71, 8'hF0);
        chk_rd(8'h71, 8'hF0);
        host.reg_wr(8'h72, 8'hFF);
        chk_rd(8'h72, 8'hCF);
        host.reg_wr(8'h73, 8'hA5);
        chk_rd(8'h73, 8'hA5);
        host.reg_wr(8'h73, 8'h00);
        host.reg_wr(8'h71, 8'h00);
        foreach (sel[k])
        begin
            host.reg_wr(8'h72, sel[k]);
            host.reg_wr(8'h71, 8'h02);
            cyc_wait(3);
            cmp_sig(irq_q, exp_irq[k]);
            cmp_sig(keyboard_reset_output_n_q, (k == 0) ? 1'h0 : 1'h1);
            if (k == 0)
                cyc_wait(110);
            chk_rd(8'h71, 8'h01);
            host.reg_wr(8'h71, 8'h01);
            cyc_wait(3);
            cmp_sig(irq_q, 16'h0000);
        end
        host.reg_wr(8'h72, 8'h83);
        host.reg_wr(8'h73, 8'h02);
        cyc_wait(2 * CPS - 10);
        cmp_sig(irq_q, 16'h0000);
        cyc_wait(15);
        cmp_sig(irq_q, 16'h0008);
        host.reg_wr(8'h73, 8'h00);
        host.reg_wr(8'h71, 8'h01);
        host.reg_wr(8'h72, 8'h03);
        host.reg_wr(8'h73, 8'h01);
        cyc_wait(100);
        cmp_sig(irq_q, 16'h0000);
        cyc_wait(60 * CPS);
        cmp_sig(irq_q, 16'h0008);
        host.reg_wr(8'h72, 8'h83);
        host.reg_wr(8'h73, 8'h02);
        host.reg_wr(8'h73, 8'h00);
        host.reg_wr(8'h71, 8'h01);
        cyc_wait(3 * CPS);
        cmp_sig(irq_q, 16'h0000);
        for (int k = 0; k < 4; k++)
        begin
            host.reg_wr(8'h71, 8'h80 >> k);
            host.reg_wr(8'h73, 8'h02);
            repeat (4)
            begin
                cyc_wait(CPS);
                if (k == 3)
                    host.rd(16'h0201, d);
                else
                    host.evt(3'h4 >> k);
            end
            cmp_sig(irq_q, 16'h0000);
            cyc_wait(2 * CPS + 5);
            cmp_sig(irq_q, 16'h0008);
            host.reg_wr(8'h73, 8'h00);
            host.reg_wr(8'h71, 8'h01);
        end
        host.reg_wr(8'h73, 8'h55);
        host.reg_wr(8'h02, 8'h01);
        cmp_sig(config_mode_q, 1'h1);
        host.reg_wr(8'h07, 8'h07);
        chk_rd(8'h73, 8'h00);
        chk_rd(8'h02, 8'h00);
        host.reg_wr(8'h02, 8'h02);
        cmp_sig(config_mode_q, 1'h0);
        host.rd(16'h002F, d);
        cmp_reg(d, 8'h00);
        host.key(32'h87015555);
        kbd_strap = 1'b0;
        rst = 1'b1;
        cyc_wait(12);
        rst = 1'b0;
        cmp_sig(config_mode_q, 1'h0);
        cmp_sig(kbd_ctrl_enable_q, 1'h0);
        end_sim();
    end
endmodule // swc_watchdog_config_tb_top

bind swc_watchdog_config swc_watchdog_config_asserts #(.CYC_PER_SEC(CYC_PER_SEC)) i_chk
(
    .clk(clk), .rst(rst), .io_req(io_req), .reload_evt(reload_evt),
    .kbd_strap(kbd_strap), .io_rdata_q(io_rdata_q), .io_rvalid_q(io_rvalid_q),
    .kbd_ctrl_enable_q(kbd_ctrl_enable_q), .config_mode_q(config_mode_q),
    .keyboard_reset_output_n_q(keyboard_reset_output_n_q), .irq_q(irq_q)
);
